// *** include/port3_pkg.sv ***
// Constants and types shared by the third-port data interface.
// Assumes a single system clock; the reference clock is a sampled input and the serial clocks are generated from the system clock.
package port3_pkg;
  // ************************************************************
  // Interface modes
  // ************************************************************
  typedef enum logic [1:0] {MODE_OFF, MODE_RMII, MODE_SNI} port_mode_t;

  // ************************************************************
  // Clock and timing figures
  // ************************************************************
  localparam int SYS_CLK_HZ = 10000000;   // System clock rate
  localparam int REF_CLK_HZ = 50000000;   // Reference clock rate of the reduced mode
  localparam int SLOW_REPEAT = 10;        // Reference edges per di-bit at the slow rate
  localparam int SNI_HALF_DEF = 4;        // System cycles per half period of the serial clock
  localparam int BUF_DEPTH = 2;           // Outbound buffer entries
  localparam int DIBIT_W = 2;             // Width of one di-bit
  localparam int PIN_DATA_W = 4;          // Width of the data pins
  localparam int SYNC_W = 4;              // Synchronised inbound pins: error, enable, two data
  localparam logic [3:0] SLOT_LAST = 4'h9; // Last slot count at the slow rate
endpackage

// *** rtl/port3_link.sv ***
// Third-port data interface: reduced (di-bit) mode and 7-wire serial mode.
// Assumes mode and speed settings are static while frames flow; pins arrive asynchronously.
`timescale 1ns/1ns

// Contract
// - The reduced mode carries traffic at both the fast and the slow network rate on the same pins.
// - All reduced-mode timing follows one externally supplied 50 MHz reference clock taken as an input.
// - Transmit and receive paths are separate and independent, each two bits wide.
// - The block drives receive-valid and the receive di-bit and takes transmit enable and di-bit as inputs.
// - No receive-error output is driven; erroneous frames are dropped inside the device.
// - A far PHY reports receive errors on the transmit-error input, which marks the frame for dropping.
// - In reduced mode a collision is derived from receive-valid and transmit enable being active together.
// - The same pins serve a far PHY or a far MAC, with the error signal unused toward a MAC.
// - In serial mode the block acts as the PHY and supplies separate transmit and receive clocks.
// - Serial mode moves one unencoded bit per clock on bit 0 of each data port.
// - Transmit enable marks valid inbound bits; receive-valid marks valid outbound bits.
// - In half-duplex serial operation the collision output rises during a collision.
module port3_link #(
  parameter int SNI_HALF = port3_pkg::SNI_HALF_DEF
) (
  input wire logic mclk,                               // System clock
  input wire logic rst,                                // Synchronous reset, active high
  input wire port3_pkg::port_mode_t mode_sel,          // Selected interface mode
  input wire logic speed_10,                           // Slow network rate
  input wire logic half_duplex,                        // Half-duplex operation
  input wire logic port3_reference_clock_in,           // Reduced-mode reference clock pin
  input wire logic port3_tx_enable_in,                 // Transmit enable pin
  input wire logic [3:0] port3_tx_data_in,             // Transmit data pins
  input wire logic port3_tx_error_in,                  // Transmit error pin
  output logic port3_rx_valid_out,                     // Receive valid / carrier sense pin
  output logic [3:0] port3_rx_data_out,                // Receive data pins
  output logic port3_tx_clock,                         // Serial transmit clock pin
  output logic port3_rx_clock,                         // Serial receive clock pin
  output logic port3_collision_out,                    // Serial collision pin
  output logic pins_oe,                                // High while this block owns the pins
  input wire logic [1:0] up_data,                      // Outbound di-bit from the switch
  input wire logic up_valid,                           // Outbound di-bit valid
  output logic up_ready,                               // Buffer can take a di-bit
  output logic [1:0] dn_data,                          // Inbound di-bit to the switch
  output logic dn_valid,                               // Inbound di-bit valid, one cycle
  output logic dn_end,                                 // Inbound frame ended, one cycle
  output logic dn_drop,                                // Ended frame must be discarded, one cycle
  output logic mac_collision                           // Collision seen, level
);
  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (SNI_HALF < 4) begin : g_bad_half
    $error("SNI_HALF must cover the input synchroniser delay");
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  wire is_rmii = (mode_sel == port3_pkg::MODE_RMII);
  wire is_sni = (mode_sel == port3_pkg::MODE_SNI);
  wire is_on = is_rmii | is_sni;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic ref_s1_r, ref_s2_r, ref_s3_r;
  logic [port3_pkg::SYNC_W-1:0] in_s1_r, in_s2_r;

  // Two flops on every inbound pin in use (data pins 3:2 are not sampled), a third for edge finding
  always_ff @(posedge mclk) begin
    ref_s1_r <= port3_reference_clock_in;
    ref_s2_r <= ref_s1_r;
    ref_s3_r <= ref_s2_r;
    in_s1_r <= {port3_tx_error_in, port3_tx_enable_in, port3_tx_data_in[1:0]};
    in_s2_r <= in_s1_r;
  end

  wire ref_rise = ref_s2_r & ~ref_s3_r;
  wire en_s = in_s2_r[2];
  wire er_s = in_s2_r[3];
  wire [1:0] d_s = in_s2_r[1:0];

  // ************************************************************
  // Link timing: slow-rate slots and the serial clock
  // ************************************************************
  logic [3:0] slot_r, slot_nxt;
  logic [15:0] div_r, div_nxt;
  logic sclk_r;

  wire div_wrap = (div_r == 16'(SNI_HALF - 1));
  wire sni_rise = is_sni & div_wrap & ~sclk_r;
  wire slot_zero = (slot_r == 4'h0);
  wire rmii_tick = is_rmii & ref_rise & (~speed_10 | slot_zero);
  wire tick = rmii_tick | sni_rise;

  assign slot_nxt = (~is_rmii | ~speed_10) ? 4'h0 :
                    ~ref_rise ? slot_r :
                    (slot_r == port3_pkg::SLOT_LAST) ? 4'h0 : slot_r + 4'h1;
  assign div_nxt = (~is_sni | div_wrap) ? 16'h0000 : div_r + 16'h0001;

  // Slot counter and serial clock divider
  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_r <= 4'h0;
      div_r <= 16'h0000;
      sclk_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      div_r <= div_nxt;
      sclk_r <= is_sni & (sclk_r ^ div_wrap);
    end
  end

  // ************************************************************
  // Outbound two-entry buffer
  // ************************************************************
  logic [1:0] buf_r [port3_pkg::BUF_DEPTH];
  logic wptr_r, rptr_r;
  logic [1:0] cnt_r, cnt_nxt;
  logic ph_out_r;

  wire push = up_valid & up_ready;
  wire pop_slot = tick & (is_rmii | ph_out_r);
  wire pop = pop_slot & (cnt_r != 2'h0);
  assign cnt_nxt = cnt_r + 2'(push) - 2'(pop);

  // Buffer storage and pointers; the drain stalls until a link slot
  always_ff @(posedge mclk) begin
    if (rst) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r <= 2'h0;
      up_ready <= 1'b0;
    end else begin
      if (push) begin
        buf_r[wptr_r] <= up_data;
      end
      wptr_r <= wptr_r ^ push;
      rptr_r <= rptr_r ^ pop;
      cnt_r <= cnt_nxt;
      up_ready <= (cnt_nxt != 2'(port3_pkg::BUF_DEPTH));
    end
  end

  // ************************************************************
  // Outbound launch onto the pins
  // ************************************************************
  wire [1:0] head = buf_r[rptr_r];
  wire have = (cnt_r != 2'h0);
  wire send_bit = ph_out_r ? head[1] : head[0];

  // Launch on each slot; valid drops when the buffer runs dry
  always_ff @(posedge mclk) begin
    if (rst || !is_on) begin
      port3_rx_valid_out <= 1'b0;
      port3_rx_data_out <= 4'h0;
      ph_out_r <= 1'b0;
    end else if (tick) begin
      port3_rx_valid_out <= have;
      if (is_rmii) begin
        port3_rx_data_out <= have ? {2'b00, head} : 4'h0;
      end else begin
        port3_rx_data_out <= have ? {3'b000, send_bit} : 4'h0;
        ph_out_r <= have & ~ph_out_r;
      end
    end
  end

  // Pin ownership and serial clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_oe <= 1'b0;
      port3_tx_clock <= 1'b0;
      port3_rx_clock <= 1'b0;
    end else begin
      pins_oe <= is_on;
      port3_tx_clock <= sclk_r;
      port3_rx_clock <= sclk_r;
    end
  end

  // ************************************************************
  // Inbound capture
  // ************************************************************
  logic in_frame_r, err_r, ph_in_r, bit0_r;

  // Sample on each slot; reduced-mode errors mark the frame for dropping
  always_ff @(posedge mclk) begin
    if (rst || !is_on) begin
      in_frame_r <= 1'b0;
      err_r <= 1'b0;
      ph_in_r <= 1'b0;
      bit0_r <= 1'b0;
      dn_valid <= 1'b0;
      dn_end <= 1'b0;
      dn_drop <= 1'b0;
      dn_data <= 2'b00;
    end else begin
      dn_valid <= 1'b0;
      dn_end <= 1'b0;
      dn_drop <= 1'b0;
      if (tick && en_s) begin
        in_frame_r <= 1'b1;
        err_r <= (err_r & in_frame_r) | (er_s & is_rmii);
        if (is_rmii) begin
          dn_data <= d_s;
          dn_valid <= 1'b1;
        end else begin
          bit0_r <= d_s[0];
          ph_in_r <= ~ph_in_r;
          dn_data <= {d_s[0], bit0_r};
          dn_valid <= ph_in_r;
        end
      end else if (tick && in_frame_r) begin
        in_frame_r <= 1'b0;
        ph_in_r <= 1'b0;
        dn_end <= 1'b1;
        dn_drop <= err_r;
      end
    end
  end

  // ************************************************************
  // Collision
  // ************************************************************
  wire coll = half_duplex & port3_rx_valid_out & en_s;

  // Collision to the MAC, and to the pin in serial mode only
  always_ff @(posedge mclk) begin
    if (rst) begin
      mac_collision <= 1'b0;
      port3_collision_out <= 1'b0;
    end else begin
      mac_collision <= is_on & coll;
      port3_collision_out <= is_sni & coll;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_off_quiet;
    @(posedge mclk) disable iff (rst) !is_on |=> !port3_rx_valid_out && !pins_oe;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("pins driven with no mode");

  property p_slow_hold;
    @(posedge mclk) disable iff (rst) is_rmii && speed_10 && ref_rise && !slot_zero |-> !tick;
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow di-bit not held ten edges");

  property p_launch_on_slot;
    @(posedge mclk) disable iff (rst)
      is_on && $stable(mode_sel) && $changed(port3_rx_data_out) |-> $past(tick);
  endproperty
  a_launch_on_slot: assert property (p_launch_on_slot) else $error("data changed off a slot");

  property p_sni_bit0;
    @(posedge mclk) disable iff (rst) is_sni |=> port3_rx_data_out[3:1] == 3'b000;
  endproperty
  a_sni_bit0: assert property (p_sni_bit0) else $error("serial data off bit 0");

  property p_sni_col;
    @(posedge mclk) disable iff (rst) is_sni && half_duplex && port3_rx_valid_out && en_s
      |=> port3_collision_out ##0 mac_collision;
  endproperty
  a_sni_col: assert property (p_sni_col) else $error("collision not signalled");

  property p_rmii_no_pin_col;
    @(posedge mclk) disable iff (rst) is_rmii |=> !port3_collision_out;
  endproperty
  a_rmii_no_pin_col: assert property (p_rmii_no_pin_col) else $error("collision pin in reduced mode");

  property p_drop_at_end;
    @(posedge mclk) disable iff (rst) dn_drop |-> dn_end && !dn_valid;
  endproperty
  a_drop_at_end: assert property (p_drop_at_end) else $error("drop outside frame end");

  // A frame closing with its error mark set must be discarded at its end
  property p_err_drops;
    @(posedge mclk) disable iff (rst)
      is_on && tick && in_frame_r && !en_s && err_r
      |=> dn_drop && dn_end;
  endproperty
  a_err_drops: assert property (p_err_drops) else $error("error frame not dropped");

  // An error flagged on a reduced-mode slot marks the running frame
  property p_err_mark;
    @(posedge mclk) disable iff (rst) is_rmii && tick && en_s && er_s |=> err_r && in_frame_r;
  endproperty
  a_err_mark: assert property (p_err_mark) else $error("error input not recorded");

  // Serial clocks stay low once serial mode is left
  property p_sclk_idle;
    @(posedge mclk) disable iff (rst) !is_sni ##1 !is_sni |=> !port3_tx_clock && !port3_rx_clock;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock outside serial mode");

  property p_valid_cause;
    @(posedge mclk) disable iff (rst) dn_valid |-> $past(en_s) && $past(tick);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("inbound valid without enable");

  property p_full_stalls;
    @(posedge mclk) disable iff (rst) cnt_r == 2'h2 && !pop |=> !up_ready ##0 cnt_r == 2'h2;
  endproperty
  a_full_stalls: assert property (p_full_stalls) else $error("full buffer accepted");

endmodule // port3_link

// *** test/port3_far_model.sv ***
// Far-side model of the third port: MAC or PHY in reduced mode, MAC in serial mode.
// Assumes the bench fills in_q before a frame and reads out_q after it.
`timescale 1ns/1ns
module port3_far_model (
  input wire logic sni,           // Serial mode selected
  input wire logic in_err,        // Mark the inbound frame as errored
  output logic ref_clk,           // Reference clock
  output logic tx_en,             // Inbound enable pin
  output logic [3:0] tx_data,     // Inbound data pins
  output logic tx_err,            // Inbound error pin
  input wire logic rx_valid,      // Outbound valid pin
  input wire logic [3:0] rx_data, // Outbound data pins
  input wire logic tx_clock,      // Serial transmit clock
  input wire logic rx_clock       // Serial receive clock
);
  // ************************************************************
  // Stimulus and capture
  // ************************************************************
  logic [1:0] in_q[$];
  logic [1:0] out_q[$];
  logic [1:0] d;

  // Launch the next inbound unit; idle lines show the inverse of the last value
  task drive;
    if (in_q.size() > 0) begin
      d = in_q.pop_front();
      tx_en <= 1'b1;
      tx_data <= {2'b00, d};
      tx_err <= in_err;
    end else begin
      tx_en <= 1'b0;
      tx_data <= {2'b00, ~tx_data[1:0]};
      tx_err <= 1'b0;
    end
  endtask

  // Free-running reference clock, phase unrelated to the system clock
  initial begin
    tx_en = 1'b0;
    tx_data = 4'h0;
    tx_err = 1'b0;
    ref_clk = 1'b0;
    #137;
    forever #400 ref_clk = ~ref_clk;
  end

  // Reduced mode: launch and sample on the rising reference edge
  always @(posedge ref_clk) begin
    if (!sni) begin
      if (rx_valid === 1'b1) out_q.push_back(rx_data[1:0]);
      drive();
    end
  end

  // Serial mode: this side is the MAC, launching on the falling clock edge
  always @(negedge tx_clock) if (sni) drive();

  // Serial outbound bits sampled mid-bit
  always @(negedge rx_clock) if (sni && rx_valid === 1'b1) out_q.push_back({1'b0, rx_data[0]});
endmodule // port3_far_model

// *** test/test_rmii_sni_port_interface.sv ***
// Self-checking bench of the third-port data interface with a far-side model.
// Assumes port3_pkg and port3_link are compiled first.
`timescale 1ns/1ns
module test_rmii_sni_port_interface;
  // ************************************************************
  // Bench
  // ************************************************************
  logic mclk, rst, speed_10, half_duplex, up_valid, in_err;
  port3_pkg::port_mode_t mode_sel;
  logic [1:0] up_data, dn_data;
  logic ref_clk, tx_en, tx_err, rx_valid, tx_clock, rx_clock, col, oe, up_ready, dn_valid, dn_end, dn_drop, mac_col;
  logic [3:0] tx_data, rx_data;
  logic [1:0] dn_q[$];
  int fail_count, tests_run, end_cnt;
  logic drop_seen, col_seen, pcol_seen, stall_seen;

  port3_link u_dut (.mclk(mclk), .rst(rst), .mode_sel(mode_sel), .speed_10(speed_10), .half_duplex(half_duplex),
    .port3_reference_clock_in(ref_clk), .port3_tx_enable_in(tx_en), .port3_tx_data_in(tx_data),
    .port3_tx_error_in(tx_err), .port3_rx_valid_out(rx_valid), .port3_rx_data_out(rx_data),
    .port3_tx_clock(tx_clock), .port3_rx_clock(rx_clock), .port3_collision_out(col), .pins_oe(oe),
    .up_data(up_data), .up_valid(up_valid), .up_ready(up_ready), .dn_data(dn_data), .dn_valid(dn_valid),
    .dn_end(dn_end), .dn_drop(dn_drop), .mac_collision(mac_col));
  port3_far_model u_far (.sni(mode_sel == port3_pkg::MODE_SNI), .in_err(in_err), .ref_clk(ref_clk), .tx_en(tx_en),
    .tx_data(tx_data), .tx_err(tx_err), .rx_valid(rx_valid), .rx_data(rx_data), .tx_clock(tx_clock),
    .rx_clock(rx_clock));

  always #50 mclk = ~mclk;

  // Compare one value and count it
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Copies of one di-bit seen on the pins at the given rate
  function automatic int reps(input logic slow);
    return slow ? port3_pkg::SLOW_REPEAT : 1;
  endfunction

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Monitor of the switch-side outputs
  always @(posedge mclk) begin
    if (dn_valid === 1'b1) dn_q.push_back(dn_data);
    if (dn_end === 1'b1) begin
      end_cnt++;
      drop_seen = dn_drop;
    end
    if (mac_col === 1'b1) col_seen = 1'b1;
    if (col === 1'b1) pcol_seen = 1'b1;
    if (up_valid && up_ready === 1'b0) stall_seen = 1'b1;
  end

  // One frame each way in the given mode, then compare both streams
  task automatic run(input port3_pkg::port_mode_t m, input logic slow, hd, err, input int nout, nin);
    logic [1:0] d;
    logic [1:0] exp_out[$];
    logic [1:0] exp_dn[$];
    int k;
    logic sni;
    sni = (m == port3_pkg::MODE_SNI);
    mode_sel <= m;
    speed_10 <= slow;
    half_duplex <= hd;
    in_err <= err;
    repeat (20) @(posedge mclk);
    u_far.out_q.delete();
    dn_q.delete();
    end_cnt = 0;
    {drop_seen, col_seen, pcol_seen, stall_seen} = 4'h0;
    check(oe, 1'b1);
    for (k = 0; k < nin; k++) begin
      d = 2'($urandom);
      exp_dn.push_back(d);
      if (sni) begin
        u_far.in_q.push_back({1'b0, d[0]});
        u_far.in_q.push_back({1'b0, d[1]});
      end else repeat (reps(slow)) u_far.in_q.push_back(d);
    end
    for (k = 0; k < nout; k++) begin
      d = 2'($urandom);
      if (sni) begin
        exp_out.push_back({1'b0, d[0]});
        exp_out.push_back({1'b0, d[1]});
      end else repeat (reps(slow)) exp_out.push_back(d);
      up_valid <= 1'b1;
      up_data <= d;
      @(posedge mclk);
      while (up_ready !== 1'b1) @(posedge mclk);
    end
    up_valid <= 1'b0;
    k = 0;
    while (u_far.out_q.size() < exp_out.size() && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    repeat (300) @(posedge mclk);
    check(u_far.out_q.size(), exp_out.size());
    foreach (exp_out[i]) if (i < u_far.out_q.size()) check(u_far.out_q[i], exp_out[i]);
    check(dn_q.size(), exp_dn.size());
    foreach (exp_dn[i]) if (i < dn_q.size()) check(dn_q[i], exp_dn[i]);
    check(end_cnt, nin > 0);
    check(drop_seen, err);
    check(col_seen, hd && nout > 0 && nin > 0);
    check(pcol_seen, hd && sni && nout > 0 && nin > 0);
    if (slow) check(stall_seen, 1'b1);
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    mode_sel = port3_pkg::MODE_OFF;
    {speed_10, half_duplex, up_valid, in_err} = 4'h0;
    up_data = 2'h0;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    void'($urandom(54412));
    repeat (3) @(posedge mclk);
    check(oe, 1'b0);
    run(port3_pkg::MODE_RMII, 1'b0, 1'b0, 1'b0, 4 + $urandom % 9, 4 + $urandom % 9);
    run(port3_pkg::MODE_RMII, 1'b0, 1'b0, 1'b1, 0, 6);
    run(port3_pkg::MODE_RMII, 1'b1, 1'b0, 1'b0, 6, 4);
    run(port3_pkg::MODE_RMII, 1'b0, 1'b1, 1'b0, 10, 10);
    run(port3_pkg::MODE_SNI, 1'b0, 1'b0, 1'b0, 4 + $urandom % 9, 4 + $urandom % 9);
    run(port3_pkg::MODE_SNI, 1'b0, 1'b1, 1'b0, 10, 10);
    mode_sel <= port3_pkg::MODE_OFF;
    repeat (5) @(posedge mclk);
    check({oe, tx_clock, rx_valid}, 3'h0);
    conclude();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 80000);
    fail_count++;
    conclude();
  end
endmodule // test_rmii_sni_port_interface
